// File: core/irc_carrier_generator.v
// infrared carrier generator: 8-bit auto-reload counter with duty compare
`timescale 1ns/1ps
`default_nettype none
`include "irc_carrier_regs.vh"

module irc_carrier_generator #(
  parameter CNT_W = 8
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire power_down_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output wire [7:0] reg_rdata_out,
  output wire ir_carrier_out
);

  ////////////////////////////////////////////////////////////////////////
  // register decode

  wire wr_reload;
  wire wr_mode;
  wire wr_counter;
  wire wr_duty;

  assign wr_reload = reg_wr_in && (reg_addr_in == `IRC_OFF_RELOAD);
  assign wr_mode = reg_wr_in && (reg_addr_in == `IRC_OFF_MODE);
  assign wr_counter = reg_wr_in && (reg_addr_in == `IRC_OFF_COUNTER);
  assign wr_duty = reg_wr_in && (reg_addr_in == `IRC_OFF_DUTY);

  reg ir_output_enable_q;
  reg [CNT_W-1:0] carrier_counter_q;
  reg [CNT_W-1:0] carrier_counter_d;
  reg [CNT_W-1:0] carrier_duty_compare_q;
  reg [7:0] rdata_q;

  wire [CNT_W-1:0] reload_active;
  wire wrap;
  wire match;
  wire start;

  ////////////////////////////////////////////////////////////////////////
  // control registers

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      ir_output_enable_q <= 1'b0;
      carrier_duty_compare_q <= `IRC_RST_DUTY;
    end else begin
      if (wr_mode) begin
        ir_output_enable_q <= reg_wdata_in[`IRC_MODE_ENABLE_BIT];
      end
      if (wr_duty) begin
        carrier_duty_compare_q <= reg_wdata_in[CNT_W-1:0];
      end
    end
  end

  // rising edge of enable restarts the carrier high
  assign start = wr_mode && reg_wdata_in[`IRC_MODE_ENABLE_BIT] && !ir_output_enable_q;

  // next enable value, so a clearing write drops the pin at the same edge as a setting one raises it
  wire ir_output_enable_d;
  assign ir_output_enable_d = wr_mode ? reg_wdata_in[`IRC_MODE_ENABLE_BIT] : ir_output_enable_q;

  ////////////////////////////////////////////////////////////////////////
  // counter: runs only while enabled, so the software-loaded start value holds

  assign wrap = ir_output_enable_q && (carrier_counter_q == `IRC_CNT_MAX);
  assign match = ir_output_enable_q && !wrap && (carrier_counter_q + 8'h01 == carrier_duty_compare_q);

  always @* begin
    carrier_counter_d = carrier_counter_q;
    if (wr_counter) begin
      carrier_counter_d = reg_wdata_in[CNT_W-1:0];
    end else if (wrap) begin
      carrier_counter_d = reload_active;
    end else if (ir_output_enable_q) begin
      carrier_counter_d = carrier_counter_q + 8'h01;
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      carrier_counter_q <= `IRC_RST_COUNTER;
    end else begin
      carrier_counter_q <= carrier_counter_d;
    end
  end

  irc_reload_buffer #(
    .WIDTH(CNT_W)
  ) u_reload (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_en_in(wr_reload),
    .wr_data_in(reg_wdata_in[CNT_W-1:0]),
    .transfer_in(wrap),
    .active_out(reload_active)
  );

  // high from reload to duty, low from duty to 256
  irc_phase_out u_phase (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .enable_in(ir_output_enable_d),
    .power_down_in(power_down_in),
    .start_in(start),
    .match_in(match),
    .wrap_in(wrap),
    .ir_out(ir_carrier_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // read port; reload and duty are write-only and read zero, no flags

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `IRC_OFF_MODE: rdata_q <= {7'h00, ir_output_enable_q};
        `IRC_OFF_COUNTER: rdata_q <= carrier_counter_q;
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata_out = rdata_q;

endmodule // irc_carrier_generator
`default_nettype wire

// File: core/irc_carrier_regs.vh
// register offsets, field positions and reset values of the carrier generator
`ifndef IRC_CARRIER_REGS_VH
`define IRC_CARRIER_REGS_VH

`define IRC_ADDR_W 8
`define IRC_DATA_W 8
`define IRC_OFF_RELOAD 8'hcd
`define IRC_OFF_MODE 8'hda
`define IRC_OFF_COUNTER 8'hdb
`define IRC_OFF_DUTY 8'he8
`define IRC_MODE_ENABLE_BIT 0
`define IRC_RST_RELOAD 8'h00
`define IRC_RST_MODE 8'h00
`define IRC_RST_COUNTER 8'h00
`define IRC_RST_DUTY 8'h00
`define IRC_CNT_MAX 8'hff
`define IRC_RESET_SYNC_CYCLES 1

`endif

// File: core/irc_phase_out.v
// carrier output phase flop with forced-low gating
`timescale 1ns/1ps
`default_nettype none

module irc_phase_out (
  input wire clk_in,
  input wire sys_rst_in,
  input wire enable_in,
  input wire power_down_in,
  input wire start_in,
  input wire match_in,
  input wire wrap_in,
  output wire ir_out
);

  reg phase_q;
  reg phase_d;
  reg pin_q;

  always @* begin
    phase_d = phase_q;
    if (start_in || wrap_in) begin
      phase_d = 1'b1;
    end else if (match_in) begin
      phase_d = 1'b0;
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      phase_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      pin_q <= enable_in && !power_down_in && phase_d;
    end
  end

  assign ir_out = pin_q;

endmodule // irc_phase_out
`default_nettype wire

// File: core/irc_reload_buffer.v
// double-buffered reload value: holding stage and active stage
`timescale 1ns/1ps
`default_nettype none
`include "irc_carrier_regs.vh"

module irc_reload_buffer #(
  parameter WIDTH = 8
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire wr_en_in,
  input wire [WIDTH-1:0] wr_data_in,
  input wire transfer_in,
  output wire [WIDTH-1:0] active_out
);

  reg [WIDTH-1:0] hold_q;
  reg [WIDTH-1:0] active_q;

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      hold_q <= `IRC_RST_RELOAD;
      active_q <= `IRC_RST_RELOAD;
    end else begin
      if (wr_en_in) begin
        hold_q <= wr_data_in;
      end
      // a write in the overflow cycle itself is passed straight through
      if (transfer_in) begin
        active_q <= wr_en_in ? wr_data_in : hold_q;
      end
    end
  end

  assign active_out = active_q;

endmodule // irc_reload_buffer
`default_nettype wire

// File: verification/irc_checker.sv
// port assertions for the carrier generator
`timescale 1ns/1ps
`default_nettype none
module irc_checker (
  input wire clk_in,
  input wire sys_rst_in,
  input wire power_down_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire ir_carrier_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic en_q;
  wire mode_wr = reg_wr_in && reg_addr_in == 8'hda;
  wire cnt_rd = reg_rd_in && reg_addr_in == 8'hdb;
  // shadow of the enable bit, so checks need not read it back
  always_ff @(posedge clk_in) en_q <= sys_rst_in ? 1'b0 : mode_wr ? reg_wdata_in[0] : en_q;
  sequence two_reads;
    cnt_rd && en_q ##1 cnt_rd && en_q && reg_rdata_out != 8'hff;
  endsequence
  chk_pd_low: assert property (power_down_in |=> !ir_carrier_out) else $error("pin high");
  chk_dis_low: assert property (mode_wr && !reg_wdata_in[0] |=> !ir_carrier_out) else $error("pin on");
  chk_rst_low: assert property ($fell(sys_rst_in) |-> !ir_carrier_out) else $error("pin after reset");
  chk_en_start: assert property (mode_wr && reg_wdata_in[0] && !en_q && !power_down_in |=> ir_carrier_out)
    else $error("no start");
  chk_mode_read: assert property (reg_rd_in && reg_addr_in == 8'hda |=> reg_rdata_out[0] == en_q)
    else $error("mode read");
  chk_cnt_step: assert property (two_reads |=> reg_rdata_out == $past(reg_rdata_out) + 8'h01)
    else $error("count step");
  chk_rise_gate: assert property ($rose(ir_carrier_out) |-> en_q && !$past(power_down_in))
    else $error("bad rise");
  chk_wo_zero: assert property (reg_rd_in && reg_addr_in inside {8'hcd, 8'he8} |=> reg_rdata_out == 8'h00)
    else $error("wo read");
endmodule // irc_checker
bind irc_carrier_generator irc_checker u_chk (.*);
`default_nettype wire

// File: verification/irc_ir_led_model.sv
// emitter transistor seen as a meter of high and low phase lengths
`timescale 1ns/1ps
`default_nettype none
module irc_ir_led_model (
  input wire clk_in,
  input wire base_in,
  output logic [8:0] high_len_out,
  output logic [8:0] low_len_out
);
  logic prev_q = 1'b0;
  logic [8:0] run_q = 9'h000;
  always @(posedge clk_in) begin
    if (base_in === prev_q) run_q <= run_q + 9'h001;
    else begin
      if (prev_q) high_len_out <= run_q;
      else low_len_out <= run_q;
      run_q <= 9'h001;
    end
    prev_q <= base_in;
  end
endmodule // irc_ir_led_model
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench for the carrier generator
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin compares++; if ((g) !== (e)) begin bad_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
  logic clk_in = 0, sys_rst_in = 1, power_down_in = 0, reg_wr_in = 0, reg_rd_in = 0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
  wire [7:0] reg_rdata_out;
  wire ir_carrier_out;
  wire [8:0] high_len, low_len;
  int bad_count = 0, compares = 0;
  always #2 clk_in = ~clk_in;
  irc_carrier_generator DUT (.clk_in, .sys_rst_in, .power_down_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .ir_carrier_out);
  irc_ir_led_model led (.clk_in, .base_in(ir_carrier_out), .high_len_out(high_len), .low_len_out(low_len));
  task wr(input logic [7:0] a, d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1;
    @(posedge clk_in);
    reg_wr_in <= 0;
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1;
    @(posedge clk_in);
    reg_rd_in <= 0;
    @(negedge clk_in);
    `CHK("rdata", e, reg_rdata_out)
  endtask
  task t_reset;
    `CHK("pin", 1'b0, ir_carrier_out)
    rd(8'hda, 8'h00);
    rd(8'hdb, 8'h00);
    rd(8'he8, 8'h00);
    rd(8'h42, 8'h00);
  endtask
  // lengths are taken long after enable: the first overflow may still use the old reload
  task t_run(input logic [7:0] r, d);
    wr(8'hda, 8'h00);
    wr(8'hdb, r);
    wr(8'hcd, r);
    wr(8'he8, d);
    wr(8'hda, 8'h01);
    reg_addr_in <= 8'hdb;
    reg_rd_in <= 1;
    @(negedge clk_in);
    `CHK("pin", 1'b1, ir_carrier_out)
    @(negedge clk_in);
    `CHK("count", r, reg_rdata_out)
    @(posedge clk_in);
    reg_rd_in <= 0;
    @(negedge clk_in);
    `CHK("count", r + 8'h01, reg_rdata_out)
    repeat (600) @(posedge clk_in);
    @(negedge clk_in);
    `CHK("high", {1'b0, d - r}, high_len)
    `CHK("low", 9'h100 - d, low_len)
  endtask
  // counter parked at 0xff: the first wrap must still load the old reload 0x97
  task t_dbuf;
    wr(8'hda, 8'h00);
    wr(8'hdb, 8'hff);
    wr(8'hcd, 8'hb0);
    wr(8'hda, 8'h01);
    rd(8'hdb, 8'h97);
    repeat (600) @(posedge clk_in);
    @(negedge clk_in);
    `CHK("high", 9'h00a, high_len)
    `CHK("low", 9'h046, low_len)
  endtask
  task t_mid_rst;
    @(posedge clk_in);
    sys_rst_in <= 1;
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 0;
    @(negedge clk_in);
    t_reset;
  endtask
  // after reset duty equals reload, so the enabled pin stays high unless forced low
  task t_pd;
    wr(8'hda, 8'h01);
    @(posedge clk_in);
    power_down_in <= 1;
    @(posedge clk_in);
    repeat (300) begin
      @(negedge clk_in);
      `CHK("pin", 1'b0, ir_carrier_out)
    end
    @(posedge clk_in);
    power_down_in <= 0;
    @(negedge clk_in);
    @(negedge clk_in);
    `CHK("pin", 1'b1, ir_carrier_out)
    wr(8'hda, 8'h00);
    @(negedge clk_in);
    `CHK("pin", 1'b0, ir_carrier_out)
    rd(8'hda, 8'h00);
  endtask
  task stop_test;
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 0;
    @(negedge clk_in);
    t_reset;
    t_run(8'hfc, 8'hfe);
    t_run(8'h97, 8'hba);
    t_dbuf;
    t_mid_rst;
    t_pd;
    stop_test;
  end
  initial begin
    #40000;
    bad_count++;
    stop_test;
  end
endmodule // testbench
`default_nettype wire
